// ==== rtl/kwu_top.sv ====
// Key-on wakeup block: six filtered low-active key inputs, per-input
// enables, idle release, converter trigger, and an AXI4-Lite slave.
// Assumes idle_mode and wakeup_irq_enable_flag come from logic on aclk;
// key pins are asynchronous and are synchronised inside.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps

module kwu_top
  import kwu_pkg::*;
#(
  parameter int FILTER_CYC = KWU_FILTER_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [KWU_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [KWU_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Key pins, active low
  input wire logic [KWU_NUM_KEYS-1:0] key_input_n,
  // System side
  input wire logic idle_mode,
  input wire logic wakeup_irq_enable_flag,
  output logic idle_release,
  output logic adc_start_trigger,
  output logic key_wakeup_interrupt
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (FILTER_CYC < 2) begin : g_bad_filter
    $error("kwu_top: FILTER_CYC must be at least 2");
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] wakeup_enable_control; // Write-only control
  logic [KWU_NUM_KEYS-1:0] wake_enable; // Per-input enables
  logic adc_trigger_enable; // Converter trigger gate
  logic [KWU_NUM_KEYS-1:0] level; // Filtered pin levels
  logic [KWU_NUM_KEYS-1:0] level_prev; // Previous filtered levels
  logic [KWU_NUM_KEYS-1:0] key_fell; // Filtered high-to-low edges
  logic [KWU_NUM_KEYS-1:0] key_event; // Edges on enabled inputs
  logic [KWU_NUM_KEYS-1:0] irq_status; // Sticky, write one to clear
  logic [KWU_NUM_KEYS-1:0] irq_mask; // One lets a bit through
  logic [KWU_NUM_KEYS-1:0] status_clear; // Write-one-to-clear strobe
  logic aw_held; // Address captured, waiting
  logic [KWU_ADDR_W-1:0] aw_addr; // Captured write address
  logic w_held; // Data captured, waiting
  logic [7:0] w_byte; // Captured low data byte
  logic w_lane0; // Low byte lane was strobed
  logic do_write; // Both halves present this cycle
  kwu_sel_t wr_sel; // Decoded write target
  kwu_sel_t rd_sel; // Decoded read target
  logic [31:0] next_rdata; // Read data to register

  assign wake_enable = wakeup_enable_control[KWU_NUM_KEYS-1:0];
  assign adc_trigger_enable = wakeup_enable_control[KWU_ADC_EN_POS];

  // ****************************************************************
  // Key input conditioning
  // ****************************************************************
  // One synchroniser and filter per key, all six alike
  for (genvar i = 0; i < KWU_NUM_KEYS; i++) begin : g_key
    kwu_filter #(
      .CYCLES(FILTER_CYC)
    ) u_filter (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_n(key_input_n[i]),
      .level(level[i])
    );
  end

  // Remember filtered levels for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_prev <= '1;
    end else begin
      level_prev <= level;
    end
  end

  // A key press is a filtered fall; only enabled keys count
  assign key_fell = level_prev & ~level;
  assign key_event = key_fell & wake_enable;

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  // Each channel is taken once; nothing more until the response
  // is gone, so at most one write is in flight
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_sel = kwu_decode(aw_addr);

  // Capture write address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // Capture write data; only the low byte carries register bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Write response, error for unmapped or read-only targets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= KWU_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (wr_sel == KWU_SEL_NONE || wr_sel == KWU_SEL_LEVEL) begin
        s_axi_bresp <= KWU_RESP_SLVERR;
      end else begin
        s_axi_bresp <= KWU_RESP_OKAY;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Enable control; the don't-care bit is stored as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wakeup_enable_control <= KWU_ENABLE_RST;
    end else if (do_write && w_lane0 && wr_sel == KWU_SEL_ENABLE) begin
      wakeup_enable_control <= {w_byte[KWU_ADC_EN_POS], 1'b0,
                                w_byte[KWU_NUM_KEYS-1:0]};
    end
  end

  // Interrupt mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= KWU_MASK_RST;
    end else if (do_write && w_lane0 && wr_sel == KWU_SEL_MASK) begin
      irq_mask <= w_byte[KWU_NUM_KEYS-1:0];
    end
  end

  assign status_clear = (do_write && w_lane0 && wr_sel == KWU_SEL_STATUS) ?
                        w_byte[KWU_NUM_KEYS-1:0] : '0;

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= KWU_STATUS_RST;
    end else begin
      irq_status <= (irq_status & ~status_clear) | key_event;
    end
  end

  // Level interrupt while any unmasked event is pending
  assign key_wakeup_interrupt = |(irq_status & irq_mask);

  // ****************************************************************
  // Idle release and converter trigger
  // ****************************************************************
  // Release only while idle and the core accepts the interrupt;
  // without the core's enable flag the interrupt cannot end idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_release <= 1'b0;
    end else begin
      idle_release <= idle_mode && wakeup_irq_enable_flag
                      && key_wakeup_interrupt;
    end
  end

  // Start pulse, one cycle after each cycle holding any enabled key press, if allowed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_start_trigger <= 1'b0;
    end else begin
      adc_start_trigger <= adc_trigger_enable && (|key_event);
    end
  end

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_sel = kwu_decode(s_axi_araddr);

  // Read mux; the write-only control reads as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_sel == KWU_SEL_LEVEL) begin
      next_rdata[KWU_NUM_KEYS-1:0] = level;
    end else if (rd_sel == KWU_SEL_STATUS) begin
      next_rdata[KWU_NUM_KEYS-1:0] = irq_status;
    end else if (rd_sel == KWU_SEL_MASK) begin
      next_rdata[KWU_NUM_KEYS-1:0] = irq_mask;
    end
  end

  // Read response, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= KWU_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= (rd_sel == KWU_SEL_NONE) ? KWU_RESP_SLVERR : KWU_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Interrupt and sticky status
  irq_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (key_event != '0) |=> (irq_status & $past(key_event)) == $past(key_event))
    else $error("event did not set status");

  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((key_event & irq_mask) != '0 && !(do_write && wr_sel == KWU_SEL_MASK)) |=>
      key_wakeup_interrupt)
    else $error("unmasked event gave no interrupt");

  status_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (status_clear != '0) |=>
      (irq_status & $past(status_clear) & ~$past(key_event)) == '0)
    else $error("status bit survived its clear");

  enable_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((key_fell & ~wake_enable) != '0 && key_event == '0) |=>
      $stable(irq_status) || ($past(status_clear) != '0))
    else $error("disabled key changed status");

  adc_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    adc_start_trigger |-> $past(adc_trigger_enable) && ($past(key_event) != '0))
    else $error("converter trigger without cause");

  adc_fire_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (adc_trigger_enable && key_event != '0) |=> adc_start_trigger)
    else $error("converter trigger missing");

  idle_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (idle_mode && wakeup_irq_enable_flag && key_wakeup_interrupt) |=> idle_release)
    else $error("idle not released");

  idle_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    idle_release |-> $past(wakeup_irq_enable_flag) && $past(idle_mode))
    else $error("idle release without enable flag");

  enable_reset_a: assert property (@(posedge aclk)
    $rose(aresetn) |-> wakeup_enable_control == KWU_ENABLE_RST)
    else $error("enables not cleared by reset");

  level_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && rd_sel == KWU_SEL_LEVEL) |=>
      s_axi_rvalid && s_axi_rdata[KWU_NUM_KEYS-1:0] == $past(level))
    else $error("level read wrong");

  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid && !aw_held && !w_held)
    else $error("write response missing");

  // Idle release and converter trigger stay quiet without cause
  idle_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !key_wakeup_interrupt |=> !idle_release)
    else $error("idle released without interrupt");

  trigger_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !adc_trigger_enable |=> !adc_start_trigger)
    else $error("converter trigger while disabled");

  // Bus refusals
  level_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wr_sel == KWU_SEL_LEVEL) |=> s_axi_bresp == KWU_RESP_SLVERR)
    else $error("write to level register not refused");

  read_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && rd_sel == KWU_SEL_NONE) |=>
      s_axi_rvalid && s_axi_rresp == KWU_RESP_SLVERR)
    else $error("unmapped read not refused");

  lane_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && !w_lane0) |=> $stable(wakeup_enable_control) && $stable(irq_mask))
    else $error("write without low lane changed a register");

  // Outputs quiet as reset ends
  reset_quiet_a: assert property (@(posedge aclk)
    $rose(aresetn) |-> !idle_release && !adc_start_trigger && !key_wakeup_interrupt)
    else $error("outputs active after reset");

endmodule : kwu_top

// ==== shared/kwu_pkg.sv ====
// Package for the key-on wakeup block: register map, field positions,
// reset values, filter timing and the shared address decoder.
// Assumes a 125 MHz system clock and a 16-bit AXI4-Lite byte address.
package kwu_pkg;

  // ****************************************************************
  // Geometry and register map
  // ****************************************************************
  localparam int KWU_NUM_KEYS = 6;            // Key wakeup inputs
  localparam int KWU_ADDR_W = 16;             // AXI byte address width
  localparam logic [15:0] KWU_OFF_ENABLE = 16'h0fd0; // Wakeup enable control
  localparam logic [15:0] KWU_OFF_LEVEL = 16'h0fd4;  // Pin level monitor
  localparam logic [15:0] KWU_OFF_STATUS = 16'h0fd8; // Sticky event status
  localparam logic [15:0] KWU_OFF_MASK = 16'h0fdc;   // Interrupt mask

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int KWU_ADC_EN_POS = 7;          // Trigger enable bit
  localparam logic [7:0] KWU_ENABLE_RST = 8'h00;
  localparam logic [5:0] KWU_STATUS_RST = 6'h00;
  localparam logic [5:0] KWU_MASK_RST = 6'h00;
  localparam logic [1:0] KWU_RESP_OKAY = 2'h0;
  localparam logic [1:0] KWU_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int KWU_CLK_NS = 8;              // 125 MHz period
  localparam int KWU_FILTER_NS = 24000;       // Shortest accepted pulse
  // Least time, so round up
  localparam int KWU_FILTER_CYC = (KWU_FILTER_NS + KWU_CLK_NS - 1) / KWU_CLK_NS;

  // ****************************************************************
  // Address decoder, shared by read and write paths
  // ****************************************************************
  typedef enum logic [2:0] {
    KWU_SEL_NONE = 3'b000,
    KWU_SEL_ENABLE = 3'b001,
    KWU_SEL_LEVEL = 3'b010,
    KWU_SEL_STATUS = 3'b011,
    KWU_SEL_MASK = 3'b100
  } kwu_sel_t;

  function automatic kwu_sel_t kwu_decode(input logic [15:0] addr);
    kwu_sel_t sel;
    if (addr == KWU_OFF_ENABLE) begin
      sel = KWU_SEL_ENABLE;
    end else if (addr == KWU_OFF_LEVEL) begin
      sel = KWU_SEL_LEVEL;
    end else if (addr == KWU_OFF_STATUS) begin
      sel = KWU_SEL_STATUS;
    end else if (addr == KWU_OFF_MASK) begin
      sel = KWU_SEL_MASK;
    end else begin
      sel = KWU_SEL_NONE;
    end
    return sel;
  endfunction : kwu_decode

endpackage : kwu_pkg

// ==== rtl/kwu_filter.sv ====
// One key input: two-flop synchroniser followed by a stability filter.
// Assumes the pin is asynchronous to aclk and idles high.
`timescale 1ns/1ps
module kwu_filter
  import kwu_pkg::*;
#(
  parameter int CYCLES = KWU_FILTER_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_n,
  output logic level
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  localparam int CNT_W = $clog2(CYCLES + 1);
  if (CYCLES < 2) begin : g_bad
    $error("kwu_filter: CYCLES must be at least 2");
  end

  logic meta; // First stage, read only by sync
  logic sync; // Second stage
  logic [CNT_W-1:0] cnt; // Cycles the new level has stood

  // Synchroniser, resets to the idle high level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 1'b1;
      sync <= 1'b1;
    end else begin
      meta <= pin_n;
      sync <= meta;
    end
  end

  // Accept a level only after it stood the full window;
  // any bounce restarts the count, so short glitches vanish
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
      level <= 1'b1;
    end else if (sync == level) begin
      cnt <= '0;
    end else if (cnt == CNT_W'(CYCLES - 1)) begin
      level <= sync;
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  filt_window_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(level) |-> $past(cnt) == CNT_W'(CYCLES - 1))
    else $error("filter level moved before the window ended");

  filt_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cnt != '0) |-> ($past(sync) != $past(level)))
    else $error("filter counted while input matched level");

endmodule : kwu_filter

// ==== verification/kwu_key_model.sv ====
// Key switch model for the wakeup block's six key pins.
// Assumes one caller at a time and that pins idle high through pull-ups.
`timescale 1ns/1ps
module kwu_key_model
  import kwu_pkg::*;
(
  input wire logic aclk,
  output logic [KWU_NUM_KEYS-1:0] key_input_n
);
  // ********************************
  // Switch state
  // ********************************
  // Open switches read high via the pull-up
  initial begin
    key_input_n = 6'h3f;
  end

  // Close a switch; the pin is driven low until lift drives it high again
  task automatic push(input int idx);
    @(posedge aclk);
    key_input_n[idx] <= 1'b0;
  endtask : push

  // Open a switch; the pull-up restores the idle level
  task automatic lift(input int idx);
    @(posedge aclk);
    key_input_n[idx] <= 1'b1;
  endtask : lift
endmodule : kwu_key_model

// ==== verification/kwu_top_tb.sv ====
// Self-checking bench for the key wakeup block over AXI4-Lite.
// Assumes the key model file and the design package are compiled first.
`timescale 1ns/1ps
module kwu_top_tb
  import kwu_pkg::*;
;
  // ********************************
  // Settings and wires
  // ********************************
  localparam int FC = 8; // Short filter keeps the run brief
  localparam int SETTLE = FC + 6; // Sync, filter and status latency, with margin
  localparam logic [1:0] OK = KWU_RESP_OKAY;
  localparam logic [1:0] ERR = KWU_RESP_SLVERR;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, idle_mode, irq_flag, idle_release, trig, irq;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [KWU_NUM_KEYS-1:0] key_n;
  int bad_count = 0; // Mismatches
  int samples_checked = 0; // Comparisons made
  int trig_count = 0; // Converter trigger pulses seen

  kwu_top #(.FILTER_CYC(FC)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .key_input_n(key_n), .idle_mode(idle_mode), .wakeup_irq_enable_flag(irq_flag),
    .idle_release(idle_release), .adc_start_trigger(trig), .key_wakeup_interrupt(irq)
  );
  kwu_key_model key (.aclk(aclk), .key_input_n(key_n));

  // 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Count one-cycle trigger pulses
  always @(posedge aclk) begin
    if (trig === 1'b1) begin
      trig_count <= trig_count + 1;
    end
  end

  // ********************************
  // Checking and bus tasks
  // ********************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : check

  // Ready is sampled at the falling edge, so the release at the next rising edge is safe
  task automatic axi_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw_hit, w_hit, b_hit;
    n = 0;
    b_hit = 1'b0;
    r = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hit && n < 200) begin
      @(negedge aclk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      b_hit = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (n >= 200) bad_count++;
  endtask : axi_write

  task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_hit, r_hit;
    n = 0;
    r_hit = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hit && n < 200) begin
      @(negedge aclk);
      ar_hit = arvalid && arready;
      r_hit = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_hit) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (n >= 200) bad_count++;
  endtask : axi_read

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    axi_write(a, d, r);
    check("bresp", {30'h0, er}, {30'h0, r});
  endtask : wr

  // Data only compared when an OKAY answer is expected
  task automatic rd(input string what, input logic [15:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check("rresp", {30'h0, er}, {30'h0, r});
    if (er === OK) check(what, ed, d);
  endtask : rd

  // Interrupt and idle release, looked at between edges
  task automatic pins(input logic ei, input logic er);
    @(negedge aclk);
    check("interrupt", {31'h0, ei}, {31'h0, irq});
    check("idle_release", {31'h0, er}, {31'h0, idle_release});
  endtask : pins

  // One full press of key idx, then status cleared by writing ones
  task automatic ev(input int idx, input logic [5:0] es, input logic ei, input logic er);
    key.push(idx);
    repeat (SETTLE) @(posedge aclk);
    rd("level", KWU_OFF_LEVEL, 32'h3f & ~(32'h1 << idx), OK);
    rd("status", KWU_OFF_STATUS, {26'h0, es}, OK);
    pins(ei, er);
    key.lift(idx);
    repeat (SETTLE) @(posedge aclk);
    wr(KWU_OFF_STATUS, 32'h3f, OK);
    pins(1'b0, 1'b0);
  endtask : ev

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // Hang guard, far beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    final_report();
  end

  // ********************************
  // Test sequence
  // ********************************
  initial begin
    int t0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 16'h0;
    araddr = 16'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    idle_mode = 1'b0;
    irq_flag = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    irq_flag <= 1'b1;
    idle_mode <= 1'b1;
    // Reset values, and keys disabled until enabled
    rd("level", KWU_OFF_LEVEL, 32'h3f, OK);
    rd("status", KWU_OFF_STATUS, 32'h0, OK);
    rd("mask", KWU_OFF_MASK, 32'h0, OK);
    pins(1'b0, 1'b0);
    wr(KWU_OFF_MASK, 32'h3f, OK);
    ev(0, 6'h00, 1'b0, 1'b0);
    check("trigger", 32'h0, 32'(trig_count));
    $display("test reset done");
    // Write-only and unmapped places
    wr(KWU_OFF_ENABLE, 32'hbf, OK);
    rd("enable", KWU_OFF_ENABLE, 32'h0, OK);
    // Low byte lane off: the store is dropped
    wstrb <= 4'he;
    wr(KWU_OFF_MASK, 32'h0, OK);
    wstrb <= 4'hf;
    rd("mask", KWU_OFF_MASK, 32'h3f, OK);
    rd("unmapped", 16'h0ff0, 32'h0, ERR);
    wr(KWU_OFF_LEVEL, 32'h0, ERR);
    $display("test access done");
    // Glitch shorter than the filter span
    // One cycle short of the window: pin low for FC - 1 edges
    key.push(4);
    repeat (FC - 2) @(posedge aclk);
    key.lift(4);
    repeat (SETTLE) @(posedge aclk);
    rd("status", KWU_OFF_STATUS, 32'h0, OK);
    check("trigger", 32'h0, 32'(trig_count));
    $display("test glitch done");
    // Every key wakes, each giving one trigger pulse
    for (int i = 0; i < KWU_NUM_KEYS; i++) begin
      t0 = trig_count;
      ev(i, 6'(1 << i), 1'b1, 1'b1);
      check("trigger", 32'(t0 + 1), 32'(trig_count));
    end
    $display("test keys done");
    // Single enable, trigger off
    wr(KWU_OFF_ENABLE, 32'h04, OK);
    t0 = trig_count;
    ev(3, 6'h00, 1'b0, 1'b0);
    ev(2, 6'h04, 1'b1, 1'b1);
    check("trigger", 32'(t0), 32'(trig_count));
    $display("test enables done");
    // Masked event, then core flag low
    wr(KWU_OFF_ENABLE, 32'h3f, OK);
    wr(KWU_OFF_MASK, 32'h0, OK);
    ev(5, 6'h20, 1'b0, 1'b0);
    wr(KWU_OFF_MASK, 32'h3f, OK);
    irq_flag <= 1'b0;
    ev(1, 6'h02, 1'b1, 1'b0);
    // Core awake: interrupt still rises, but nothing to release
    @(posedge aclk);
    irq_flag <= 1'b1;
    idle_mode <= 1'b0;
    ev(4, 6'h10, 1'b1, 1'b0);
    $display("test mask done");
    final_report();
  end
endmodule : kwu_top_tb
